// ### lfd_pkg.sv
package lfd_pkg;
    localparam int NUM_CH = 4;
    localparam int CHAR_BITS = 10;
    // multiplier ratios selected by the transmit rate select
    localparam logic [4:0] MULT_CHAR_RATE = 5'h0A;
    localparam logic [4:0] MULT_HALF_RATE = 5'h14;
    // three-level selects
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    // serial rate bands in MBaud
    localparam logic [11:0] RATE_LOW_MIN = 12'h0C8;
    localparam logic [11:0] RATE_LOW_MAX = 12'h190;
    localparam logic [11:0] RATE_MID_MIN = 12'h190;
    localparam logic [11:0] RATE_MID_MAX = 12'h320;
    localparam logic [11:0] RATE_HIGH_MIN = 12'h320;
    localparam logic [11:0] RATE_HIGH_MAX = 12'h5DC;
    // amplitude trip levels in mV peak-to-peak
    localparam logic [9:0] AMP_LOW_MV = 10'h08C;
    localparam logic [9:0] AMP_MID_MV = 10'h118;
    localparam logic [9:0] AMP_HIGH_MV = 10'h1A4;
    // transition density: characters without a transition, and good characters to recover
    localparam int IDLE_CHARS_MAX = 6;
    localparam int IDLE_BITS_MAX = IDLE_CHARS_MAX * CHAR_BITS;
    localparam logic [6:0] IDLE_BITS_LIM = 7'(IDLE_BITS_MAX);
    localparam logic [1:0] GOOD_CHARS_REQ = 2'h3;
    // range control limits in ppm
    localparam logic [11:0] PPM_DATA_LO = 12'h6AC;
    localparam logic [11:0] PPM_DATA_HI = 12'h7A1;
    localparam logic [11:0] PPM_REF_LO = 12'h1E8;
    localparam logic [11:0] PPM_REF_HI = 12'h2DC;
    localparam logic [11:0] PPM_NORMAL = 12'h0C8;
    typedef enum logic [1:0] {
        LFD_TRACK_DATA = 2'b01,
        LFD_TRACK_REF = 2'b10
    } lfd_track_t;
endpackage

// ### lfd_link_fault_detect.sv
// Behaviour
// - tx multiplier x10 or x20, char clock out
// - speed select picks low, middle, high range
// - line input select picks receiver per channel
// - loopback feeds transmit data to recovery
// - loopback forces transmit outputs to one
// - valid only when all four checks pass
// - combined result on active-low fault output
// - common amplitude threshold, three levels
// - monitors watch only the selected receiver
// - loopback: range and transition checks only
// - loopback disables amplitude monitors
// - no transition over six characters faults
// - recover after three characters with transitions
// - range decides tracking source and fault
// - data tracking hysteresis limits
// - reference tracking hysteresis limits
// - disabled channel holds fault asserted
`timescale 1ns/100ps
module lfd_link_fault_detect
    import lfd_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // global selects
    input wire logic I_TX_MULTIPLIER_SELECT,
    input wire logic [1:0] I_SPEED_RANGE_SELECT,
    input wire logic [1:0] I_AMPLITUDE_THRESHOLD_SELECT,
    input wire logic I_LOCAL_LOOPBACK_ENABLE,
    // per-channel receive inputs
    input wire logic [NUM_CH-1:0] I_LINE_INPUT_SELECT,
    input wire logic [NUM_CH-1:0] I_RX_ENABLE,
    input wire logic [NUM_CH-1:0] I_LINE1_DATA,
    input wire logic [NUM_CH-1:0] I_LINE2_DATA,
    input wire logic [NUM_CH*10-1:0] I_LINE1_AMP_MV,
    input wire logic [NUM_CH*10-1:0] I_LINE2_AMP_MV,
    input wire logic [NUM_CH*12-1:0] I_FREQ_DIFF_PPM,
    // per-channel transmit serial data
    input wire logic [NUM_CH-1:0] I_TX_SERIAL,
    // transmit clock control
    output logic [4:0] O_TX_MULT_RATIO,
    output logic O_TX_CHAR_CLK_EN,
    output logic [11:0] O_RATE_MIN_MBAUD,
    output logic [11:0] O_RATE_MAX_MBAUD,
    // per-channel outputs
    output logic [NUM_CH-1:0] O_TX_LINE,
    output logic [NUM_CH-1:0] O_CDR_DATA,
    output logic [NUM_CH-1:0] O_TRACK_DATA,
    output logic [NUM_CH-1:0] O_LINK_FAULT_N
);
    logic [4:0] mult_q;
    logic [4:0] bit_cnt_q;
    logic [9:0] amp_trip;

    // ratio, rate and threshold selects are pins as well; filtered as one word so a
    // two-bit select never shows for a cycle a value that was never driven
    logic [4:0] gsel_pin;
    logic [4:0] gsel_s1_q;
    logic [4:0] gsel_s2_q;
    logic [4:0] gsel_s3_q;
    logic [4:0] gsel_q;
    logic mult_sel;
    logic [1:0] speed_sel;
    logic [1:0] thr_sel;

    assign gsel_pin = {I_AMPLITUDE_THRESHOLD_SELECT, I_SPEED_RANGE_SELECT,
        I_TX_MULTIPLIER_SELECT};

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            gsel_s1_q <= 5'h00;
            gsel_s2_q <= 5'h00;
            gsel_s3_q <= 5'h00;
            gsel_q <= 5'h00;
        end
        else
        begin
            gsel_s1_q <= gsel_pin;
            gsel_s2_q <= gsel_s1_q;
            gsel_s3_q <= gsel_s2_q;
            if (gsel_s3_q == gsel_s2_q)
                gsel_q <= gsel_s3_q;
        end
    end

    assign mult_sel = gsel_q[0];
    assign speed_sel = gsel_q[2:1];
    assign thr_sel = gsel_q[4:3];

    // ratio and character pacing; bit_cnt wraps at the ratio
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            mult_q <= MULT_CHAR_RATE;
            bit_cnt_q <= 5'h00;
        end
        else
        begin
            mult_q <= mult_sel ? MULT_HALF_RATE : MULT_CHAR_RATE;
            bit_cnt_q <= (bit_cnt_q + 5'h01 >= mult_q) ? 5'h00 : bit_cnt_q + 5'h01;
        end
    end

    assign O_TX_MULT_RATIO = mult_q;
    assign O_TX_CHAR_CLK_EN = (bit_cnt_q == 5'h00);

    // rate band for the chosen speed range; host must keep its reference in band
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            O_RATE_MIN_MBAUD <= RATE_LOW_MIN;
            O_RATE_MAX_MBAUD <= RATE_LOW_MAX;
        end
        else
        begin
            case (speed_sel)
                LVL_LOW:
                begin
                    O_RATE_MIN_MBAUD <= RATE_LOW_MIN;
                    O_RATE_MAX_MBAUD <= RATE_LOW_MAX;
                end
                LVL_HIGH:
                begin
                    O_RATE_MIN_MBAUD <= RATE_HIGH_MIN;
                    O_RATE_MAX_MBAUD <= RATE_HIGH_MAX;
                end
                default:
                begin
                    O_RATE_MIN_MBAUD <= RATE_MID_MIN;
                    O_RATE_MAX_MBAUD <= RATE_MID_MAX;
                end
            endcase
        end
    end

    // one trip level for all channels; an undriven select counts as middle
    always_comb
    begin
        if (thr_sel == LVL_LOW)
            amp_trip = AMP_LOW_MV;
        else if (thr_sel == LVL_HIGH)
            amp_trip = AMP_HIGH_MV;
        else
            amp_trip = AMP_MID_MV;
    end

    // loopback select is a pin: three stages, change taken when stages two and three agree
    logic [2:0] lpbk_sync_q;
    logic lpbk_q;
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            lpbk_sync_q <= 3'h0;
            lpbk_q <= 1'b0;
        end
        else
        begin
            lpbk_sync_q <= {lpbk_sync_q[1:0], I_LOCAL_LOOPBACK_ENABLE};
            if (lpbk_sync_q[2] == lpbk_sync_q[1])
                lpbk_q <= lpbk_sync_q[2];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            logic [2:0] sel_sync_q;
            logic [2:0] en_sync_q;
            logic [2:0] d1_sync_q;
            logic [2:0] d2_sync_q;
            logic sel_q;
            logic en_q;
            logic rx_bit;
            logic rx_prev_q;
            logic [9:0] amp;
            logic amp_ok;
            logic edge_seen;
            logic [6:0] idle_q;
            logic [3:0] char_pos_q;
            logic char_edge_q;
            logic [1:0] good_q;
            logic dens_fault_q;
            lfd_track_t track_q;
            logic [11:0] ppm;
            logic valid;
            logic freq_ok;
            logic char_end;
            logic idle_over;
            logic fault_n_q;

            assign ppm = I_FREQ_DIFF_PPM[ch*12 +: 12];

            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                begin
                    sel_sync_q <= 3'h0;
                    en_sync_q <= 3'h0;
                    d1_sync_q <= 3'h0;
                    d2_sync_q <= 3'h0;
                    sel_q <= 1'b0;
                    en_q <= 1'b0;
                end
                else
                begin
                    sel_sync_q <= {sel_sync_q[1:0], I_LINE_INPUT_SELECT[ch]};
                    en_sync_q <= {en_sync_q[1:0], I_RX_ENABLE[ch]};
                    d1_sync_q <= {d1_sync_q[1:0], I_LINE1_DATA[ch]};
                    d2_sync_q <= {d2_sync_q[1:0], I_LINE2_DATA[ch]};
                    if (sel_sync_q[2] == sel_sync_q[1])
                        sel_q <= sel_sync_q[2];
                    if (en_sync_q[2] == en_sync_q[1])
                        en_q <= en_sync_q[2];
                end
            end

            // loopback takes the transmit stream; otherwise the selected receiver
            always_comb
            begin
                if (lpbk_q)
                begin
                    rx_bit = I_TX_SERIAL[ch];
                    amp = 10'h000;
                end
                else if (sel_q)
                begin
                    rx_bit = d2_sync_q[2];
                    amp = I_LINE2_AMP_MV[ch*10 +: 10];
                end
                else
                begin
                    rx_bit = d1_sync_q[2];
                    amp = I_LINE1_AMP_MV[ch*10 +: 10];
                end
            end

            // amplitude monitor is off in loopback so it never blocks the result
            assign amp_ok = lpbk_q || (amp >= amp_trip);
            assign edge_seen = (rx_bit != rx_prev_q);
            assign char_end = (char_pos_q == 4'(CHAR_BITS - 1));
            assign idle_over = (idle_q >= IDLE_BITS_LIM);

            // idle run in bit times; saturates so a dead line never wraps back to good
            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                begin
                    rx_prev_q <= 1'b0;
                    idle_q <= 7'h00;
                end
                else
                begin
                    rx_prev_q <= rx_bit;
                    idle_q <= edge_seen ? 7'h00 : (idle_q == 7'h7F ? idle_q : idle_q + 7'h01);
                end
            end

            // free-running character windows; char_edge_q marks an edge earlier in the window
            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                begin
                    char_pos_q <= 4'h0;
                    char_edge_q <= 1'b0;
                end
                else
                begin
                    char_pos_q <= char_end ? 4'h0 : char_pos_q + 4'h1;
                    if (char_end)
                        char_edge_q <= 1'b0;
                    else if (edge_seen)
                        char_edge_q <= 1'b1;
                end
            end

            // adjacent characters that held an edge; an idle overrun restarts the count
            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                    good_q <= 2'h0;
                else if (idle_over)
                    good_q <= 2'h0;
                else if (char_end)
                begin
                    if (!(char_edge_q || edge_seen))
                        good_q <= 2'h0;
                    else if (good_q != GOOD_CHARS_REQ)
                        good_q <= good_q + 2'h1;
                end
            end

            // a new idle overrun wins over recovery in the same cycle
            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                    dens_fault_q <= 1'b1;
                else if (idle_over)
                    dens_fault_q <= 1'b1;
                else if (dens_fault_q && good_q == GOOD_CHARS_REQ)
                    dens_fault_q <= 1'b0;
            end

            // range control with hysteresis; indeterminate band keeps the current source
            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                    track_q <= LFD_TRACK_REF;
                else
                begin
                    case (track_q)
                        LFD_TRACK_DATA:
                            if (ppm > PPM_DATA_HI)
                                track_q <= LFD_TRACK_REF;
                        LFD_TRACK_REF:
                            if (ppm < PPM_REF_LO)
                                track_q <= LFD_TRACK_DATA;
                        default:
                            track_q <= LFD_TRACK_REF;
                    endcase
                end
            end

            // normal range is tighter than the hysteresis: tracking data alone is not enough
            assign freq_ok = (ppm <= PPM_NORMAL);
            assign valid = en_q && amp_ok && !dens_fault_q && freq_ok
                && (track_q == LFD_TRACK_DATA);

            // registered so the indicator only moves on a clock edge
            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                    fault_n_q <= 1'b0;
                else
                    fault_n_q <= valid;
            end

            assign O_LINK_FAULT_N[ch] = fault_n_q;
            assign O_TRACK_DATA[ch] = (track_q == LFD_TRACK_DATA);
            assign O_CDR_DATA[ch] = rx_bit;
            assign O_TX_LINE[ch] = lpbk_q ? 1'b1 : I_TX_SERIAL[ch];
        end
    endgenerate
endmodule // lfd_link_fault_detect

// ### lfd_assertions.sv
`timescale 1ns/100ps
module lfd_assertions
    import lfd_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // watched inputs
    input wire logic I_TX_MULTIPLIER_SELECT,
    input wire logic [1:0] I_SPEED_RANGE_SELECT,
    input wire logic I_LOCAL_LOOPBACK_ENABLE,
    input wire logic [NUM_CH-1:0] I_LINE_INPUT_SELECT,
    input wire logic [NUM_CH-1:0] I_RX_ENABLE,
    input wire logic [NUM_CH*10-1:0] I_LINE1_AMP_MV,
    input wire logic [NUM_CH*12-1:0] I_FREQ_DIFF_PPM,
    input wire logic [NUM_CH-1:0] I_TX_SERIAL,
    // watched outputs
    input wire logic [4:0] O_TX_MULT_RATIO,
    input wire logic O_TX_CHAR_CLK_EN,
    input wire logic [11:0] O_RATE_MIN_MBAUD,
    input wire logic [11:0] O_RATE_MAX_MBAUD,
    input wire logic [NUM_CH-1:0] O_TX_LINE,
    input wire logic [NUM_CH-1:0] O_CDR_DATA,
    input wire logic [NUM_CH-1:0] O_TRACK_DATA,
    input wire logic [NUM_CH-1:0] O_LINK_FAULT_N
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // pin selects pass a 3-stage filter, so relations wait for a settled select
    property p_mult;
        $stable(I_TX_MULTIPLIER_SELECT)[*6] |-> O_TX_MULT_RATIO ==
            (I_TX_MULTIPLIER_SELECT ? MULT_HALF_RATE : MULT_CHAR_RATE);
    endproperty
    a_mult: assert property (p_mult) else $error("ratio wrong");
    property p_char;
        O_TX_CHAR_CLK_EN |=> !O_TX_CHAR_CLK_EN [*8];
    endproperty
    a_char: assert property (p_char) else $error("char pulse too close");
    property p_band;
        $stable(I_SPEED_RANGE_SELECT)[*6] && I_SPEED_RANGE_SELECT == LVL_HIGH |->
            O_RATE_MIN_MBAUD == RATE_HIGH_MIN && O_RATE_MAX_MBAUD == RATE_HIGH_MAX;
    endproperty
    a_band: assert property (p_band) else $error("band wrong");
    property p_txline;
        $stable(I_LOCAL_LOOPBACK_ENABLE)[*5] |->
            O_TX_LINE == (I_LOCAL_LOOPBACK_ENABLE ? 4'hF : I_TX_SERIAL);
    endproperty
    a_txline: assert property (p_txline) else $error("tx line wrong");
    property p_cdr;
        $stable(I_LOCAL_LOOPBACK_ENABLE)[*5] && I_LOCAL_LOOPBACK_ENABLE |->
            O_CDR_DATA == I_TX_SERIAL;
    endproperty
    a_cdr: assert property (p_cdr) else $error("loop data wrong");
    property p_dis;
        $stable(I_RX_ENABLE)[*6] |-> (O_LINK_FAULT_N & ~I_RX_ENABLE) == 4'h0;
    endproperty
    a_dis: assert property (p_dis) else $error("disabled not faulted");
    property p_trk;
        (O_LINK_FAULT_N & ~$past(O_TRACK_DATA)) == 4'h0;
    endproperty
    a_trk: assert property (p_trk) else $error("good while on ref");
    property p_norm;
        $past(I_FREQ_DIFF_PPM[11:0]) > PPM_NORMAL |-> !O_LINK_FAULT_N[0];
    endproperty
    a_norm: assert property (p_norm) else $error("good outside normal range");
    property p_toref;
        O_TRACK_DATA[0] && I_FREQ_DIFF_PPM[11:0] > PPM_DATA_HI |-> ##[1:2] !O_TRACK_DATA[0];
    endproperty
    a_toref: assert property (p_toref) else $error("no switch to ref");
    property p_todata;
        !O_TRACK_DATA[0] && I_FREQ_DIFF_PPM[11:0] < PPM_REF_LO |-> ##[1:2] O_TRACK_DATA[0];
    endproperty
    a_todata: assert property (p_todata) else $error("no return to data");
    property p_amp;
        $stable({I_LOCAL_LOOPBACK_ENABLE, I_LINE_INPUT_SELECT[0]})[*5] &&
            !I_LOCAL_LOOPBACK_ENABLE && !I_LINE_INPUT_SELECT[0] &&
            I_LINE1_AMP_MV[9:0] < AMP_LOW_MV |-> ##[1:2] !O_LINK_FAULT_N[0];
    endproperty
    a_amp: assert property (p_amp) else $error("weak line not faulted");
    c_ref: cover property (O_TRACK_DATA[0] ##1 !O_TRACK_DATA[0]);
    c_up: cover property ($rose(O_LINK_FAULT_N[0]));
    c_lb: cover property (I_LOCAL_LOOPBACK_ENABLE && O_TX_LINE == 4'hF);
endmodule // lfd_assertions

bind lfd_link_fault_detect lfd_assertions u_chk (.*);

// ### lfd_remote_tx.sv
`timescale 1ns/100ps
module lfd_remote_tx
    import lfd_pkg::*;
(
    input wire logic i_clk,
    input wire logic [NUM_CH-1:0] i_active,
    output logic [NUM_CH-1:0] o_data
);
    // a stalled transmitter parks its line at the last level
    initial o_data = '0;
    always @(negedge i_clk) o_data <= o_data ^ i_active;
endmodule // lfd_remote_tx

// ### tb.sv
`timescale 1ns/100ps
module tb;
    import lfd_pkg::*;
    logic clk, rst, mul, local_loopback_enable, tx_run, ce;
    logic [1:0] spd, thr;
    logic [3:0] isel, rxen, act1, act2, txs, l1, l2, line, cdr, trk, fn;
    logic [39:0] a1, a2;
    logic [47:0] ppm;
    logic [4:0] ratio;
    logic [11:0] rmin, rmax;
    logic [11:0] bmin[3] = '{RATE_LOW_MIN, RATE_MID_MIN, RATE_HIGH_MIN};
    logic [11:0] bmax[3] = '{RATE_LOW_MAX, RATE_MID_MAX, RATE_HIGH_MAX};
    logic [11:0] pv[5] = '{12'h708, 12'h7D0, 12'h258, 12'h190, 12'h000};
    logic te[5] = '{1, 0, 0, 1, 1};
    logic fe[5] = '{0, 0, 0, 0, 1};
    wire [11:0] f = {8'h00, fn};
    wire [11:0] t = {8'h00, trk};
    int num_errors = 0;
    int total_checks = 0;
    int pulses;
    logic b;
    lfd_link_fault_detect dut (.I_CLK(clk), .I_RST(rst), .I_TX_MULTIPLIER_SELECT(mul),
        .I_SPEED_RANGE_SELECT(spd), .I_AMPLITUDE_THRESHOLD_SELECT(thr),
        .I_LOCAL_LOOPBACK_ENABLE(local_loopback_enable), .I_LINE_INPUT_SELECT(isel), .I_RX_ENABLE(rxen),
        .I_LINE1_DATA(l1), .I_LINE2_DATA(l2), .I_LINE1_AMP_MV(a1), .I_LINE2_AMP_MV(a2),
        .I_FREQ_DIFF_PPM(ppm), .I_TX_SERIAL(txs), .O_TX_MULT_RATIO(ratio),
        .O_TX_CHAR_CLK_EN(ce), .O_RATE_MIN_MBAUD(rmin), .O_RATE_MAX_MBAUD(rmax),
        .O_TX_LINE(line), .O_CDR_DATA(cdr), .O_TRACK_DATA(trk), .O_LINK_FAULT_N(fn));
    lfd_remote_tx u_far1 (.i_clk(clk), .i_active(act1), .o_data(l1));
    lfd_remote_tx u_far2 (.i_clk(clk), .i_active(act2), .o_data(l2));
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) if (tx_run) txs <= ~txs;
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic chk(input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // the whole sequence needs under 1000 cycles
    initial
    begin
        #10000;
        num_errors++;
        give_verdict;
    end
    initial
    begin
        rst = 1; mul = 0; local_loopback_enable = 0; tx_run = 0; spd = 0; thr = 0; isel = 0; rxen = 4'hF;
        act1 = 4'hF; act2 = 4'hF; txs = 0; a1 = {4{10'h12C}}; a2 = a1; ppm = '0;
        cyc(16);
        chk(12'h00A, {7'h00, ratio});
        chk(12'h000, f);
        rst = 0;
        for (int n = 0; n < 2; n++)
        begin
            mul = n[0];
            cyc(10);
            pulses = 0;
            repeat (40)
            begin
                @(negedge clk);
                if (ce === 1'b1)
                    pulses++;
            end
            chk(n ? 12'h014 : 12'h00A, {7'h00, ratio});
            chk(n ? 12'h002 : 12'h004, pulses[11:0]);
        end
        for (int n = 0; n < 3; n++)
        begin
            spd = 2'(n);
            cyc(6);
            chk(bmin[n], rmin);
            chk(bmax[n], rmax);
        end
        cyc(100);
        chk(12'h00F, f);
        chk(12'h00F, t);
        $display("test setup and link up done");
        for (int n = 0; n < 3; n++)
        begin
            thr = 2'(n);
            cyc(6);
            chk(n == 2 ? 12'h000 : 12'h00F, f);
        end
        thr = 0;
        a2[19:10] = 10'h064;
        isel = 4'h2;
        act1[1] = 0;
        cyc(10);
        chk(12'h00D, f);
        b = cdr[1];
        cyc(1);
        chk({11'h000, ~b}, {11'h000, cdr[1]});
        act1[1] = 1;
        isel = 4'h0;
        cyc(10);
        chk(12'h00F, f);
        $display("test amplitude and select done");
        act1[0] = 0;
        cyc(45);
        chk(12'h00F, f);
        cyc(25);
        chk(12'h00E, f);
        act1[0] = 1;
        cyc(10);
        chk(12'h00E, f);
        cyc(40);
        chk(12'h00F, f);
        $display("test density done");
        for (int n = 0; n < 5; n++)
        begin
            ppm[11:0] = pv[n];
            cyc(4);
            chk({8'h00, 3'h7, te[n]}, t);
            chk({8'h00, 3'h7, fe[n]}, f);
        end
        rxen = 4'hB;
        cyc(8);
        chk(12'h00B, f);
        rxen = 4'hF;
        $display("test range and enable done");
        local_loopback_enable = 1; tx_run = 1; act1 = 0; act2 = 0; a1 = '0; a2 = '0;
        cyc(60);
        chk(12'h00F, {8'h00, line});
        chk({8'h00, txs}, {8'h00, cdr});
        chk(12'h00F, f);
        tx_run = 0;
        cyc(70);
        chk(12'h000, f);
        local_loopback_enable = 0;
        cyc(12);
        chk(12'h000, f);
        $display("test loopback done");
        give_verdict;
    end
endmodule // tb
